// ==== hw/iosb_pkg.sv ====
// constants and types for the six-instruction execute block
// assumes one core clock and a decoder that presents one opcode at a time
//
// How it works
// - incr_skip_zero adds one to the file register, stores it, and leaves flags alone
// - a zero incr_skip_zero result turns the next instruction into a bubble
// - dest bit 0 writes the accumulator, 1 writes file register 0..127
// - jump_absolute loads its 11-bit operand into pc bits 10:0, no flags
// - jump_absolute fills pc bits 14:11 from latch bits 6:3
// - jump_absolute takes two instruction cycles
// - or_literal_acc ORs accumulator with literal into accumulator, updates zero
// - or_acc_reg ORs accumulator with file register to dest, updates zero
// - incr_reg adds one to file register to dest, updates zero, never skips
// - shift_left_logical: bit 7 to carry, shift left, zero in, updates zero
package iosb_pkg;

  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;
  localparam int PC_W    = 15;
  localparam int JMP_W   = 11;
  localparam int LATCH_W = 7;
  localparam int LAT_LO  = 3;
  localparam int LAT_HI  = 6;
  localparam int MSB     = 7;

  localparam logic [DATA_W-1:0]  ONE_D   = 8'h01;
  localparam logic [DATA_W-1:0]  ZERO_D  = 8'h00;
  localparam logic [PC_W-1:0]    ZERO_PC = 15'h0000;
  localparam logic [ADDR_W-1:0]  ZERO_A  = 7'h00;

  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_INCSZ  = 3'b001,
    OP_INC    = 3'b010,
    OP_ORLIT  = 3'b011,
    OP_ORREG  = 3'b100,
    OP_SHL    = 3'b101,
    OP_JUMP   = 3'b110
  } iosb_op_t;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_BUBBLE = 2'b01
  } iosb_state_t;

endpackage : iosb_pkg

// ==== hw/iosb_exec.sv ====
// execute stage for increment, OR, left shift and absolute jump
// assumes decoder holds op_i for one cycle when valid_i and honours busy_o;
// file-register read data fdata_i is valid in the same cycle as the request
`timescale 1ns/10ps
module iosb_exec
  import iosb_pkg::*;
(
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rst_b_i,
  // decoded instruction
  input  wire logic               valid_i,
  input  iosb_op_t                op_i,
  input  wire logic [ADDR_W-1:0]  faddr_i,
  input  wire logic               dest_i,
  input  wire logic [DATA_W-1:0]  lit_i,
  input  wire logic [JMP_W-1:0]   jaddr_i,
  input  wire logic [LATCH_W-1:0] pclatch_i,
  // file-register read data
  input  wire logic [DATA_W-1:0]  fdata_i,
  // file-register write
  output logic                    fwe_o,
  output logic [ADDR_W-1:0]       fwaddr_o,
  output logic [DATA_W-1:0]       fwdata_o,
  // core state
  output logic [DATA_W-1:0]       acc_o,
  output logic                    zero_o,
  output logic                    carry_o,
  // fetch control
  output logic                    pc_load_o,
  output logic [PC_W-1:0]         pc_o,
  output logic                    squash_o,
  output logic                    busy_o,
  output logic                    done_o
);

  typedef struct packed {
    iosb_state_t       st;
    logic              fwe;
    logic [ADDR_W-1:0] fwaddr;
    logic [DATA_W-1:0] fwdata;
    logic [DATA_W-1:0] acc;
    logic              zero;
    logic              carry;
    logic              pc_load;
    logic [PC_W-1:0]   pc;
    logic              squash;
    logic              busy;
    logic              done;
  } iosb_state_s_t;

  iosb_state_s_t st_ff;
  iosb_state_s_t nxt_st;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == ZERO_D);
  endfunction : is_zero

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [DATA_W-1:0] res;
    res            = ZERO_D;
    nxt_st         = st_ff;
    nxt_st.fwe     = 1'b0;
    nxt_st.pc_load = 1'b0;
    nxt_st.squash  = 1'b0;
    nxt_st.done    = 1'b0;
    nxt_st.busy    = 1'b0;
    unique case (st_ff.st)
      ST_BUBBLE:
      begin
        // second cycle of skip or jump: no work, then done
        nxt_st.st   = ST_RUN;
        nxt_st.done = 1'b1;
      end
      ST_RUN:
      begin
        if (valid_i)
        begin
          unique case (op_i)
            OP_INCSZ:
            begin
              res = fdata_i + ONE_D;
              if (is_zero(res))
              begin
                nxt_st.st     = ST_BUBBLE;
                nxt_st.squash = 1'b1;
                nxt_st.busy   = 1'b1;
              end
              else
              begin
                nxt_st.done = 1'b1;
              end
            end
            OP_INC:
            begin
              res         = fdata_i + ONE_D;
              nxt_st.zero = is_zero(res);
              nxt_st.done = 1'b1;
            end
            OP_ORLIT:
            begin
              res         = st_ff.acc | lit_i;
              nxt_st.acc  = res;
              nxt_st.zero = is_zero(res);
              nxt_st.done = 1'b1;
            end
            OP_ORREG:
            begin
              res         = st_ff.acc | fdata_i;
              nxt_st.zero = is_zero(res);
              nxt_st.done = 1'b1;
            end
            OP_SHL:
            begin
              nxt_st.carry = fdata_i[MSB];
              res          = {fdata_i[MSB-1:0], 1'b0};
              nxt_st.zero  = is_zero(res);
              nxt_st.done  = 1'b1;
            end
            OP_JUMP:
            begin
              nxt_st.pc      = {pclatch_i[LAT_HI:LAT_LO], jaddr_i};
              nxt_st.pc_load = 1'b1;
              nxt_st.squash  = 1'b1;
              nxt_st.busy    = 1'b1;
              nxt_st.st      = ST_BUBBLE;
            end
            default:
            begin
              nxt_st.done = 1'b0;
            end
          endcase
          // destination routing for file-register results
          if (op_i == OP_INCSZ || op_i == OP_INC || op_i == OP_ORREG ||
              op_i == OP_SHL)
          begin
            if (dest_i)
            begin
              nxt_st.fwe    = 1'b1;
              nxt_st.fwaddr = faddr_i;
              nxt_st.fwdata = res;
            end
            else
            begin
              nxt_st.acc = res;
            end
          end
        end
      end
      default:
      begin
        nxt_st.st = ST_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      st_ff.st      <= ST_RUN;
      st_ff.fwe     <= 1'b0;
      st_ff.fwaddr  <= ZERO_A;
      st_ff.fwdata  <= ZERO_D;
      st_ff.acc     <= ZERO_D;
      st_ff.zero    <= 1'b0;
      st_ff.carry   <= 1'b0;
      st_ff.pc_load <= 1'b0;
      st_ff.pc      <= ZERO_PC;
      st_ff.squash  <= 1'b0;
      st_ff.busy    <= 1'b0;
      st_ff.done    <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign fwe_o     = st_ff.fwe;
  assign fwaddr_o  = st_ff.fwaddr;
  assign fwdata_o  = st_ff.fwdata;
  assign acc_o     = st_ff.acc;
  assign zero_o    = st_ff.zero;
  assign carry_o   = st_ff.carry;
  assign pc_load_o = st_ff.pc_load;
  assign pc_o      = st_ff.pc;
  assign squash_o  = st_ff.squash;
  assign busy_o    = st_ff.busy;
  assign done_o    = st_ff.done;

endmodule : iosb_exec

// ==== tb/iosb_exec_asserts.sv ====
// timing and result checks for the execute block
// assumes it is bound to iosb_exec and sees only its ports
`timescale 1ns/10ps
module iosb_chk
  import iosb_pkg::*;
(
  input wire logic               mclk_i, rst_b_i, valid_i, dest_i,
  input wire logic               fwe_o, zero_o, carry_o, pc_load_o,
  input wire logic               squash_o, busy_o, done_o,
  input iosb_op_t                op_i,
  input wire logic [ADDR_W-1:0]  faddr_i, fwaddr_o,
  input wire logic [DATA_W-1:0]  lit_i, fdata_i, fwdata_o, acc_o,
  input wire logic [JMP_W-1:0]   jaddr_i,
  input wire logic [LATCH_W-1:0] pclatch_i,
  input wire logic [PC_W-1:0]    pc_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic tk;
  // busy_o stands in the bubble cycle itself, where valid_i is ignored
  assign tk = valid_i & ~busy_o;
  jump_pc_a: assert property (tk && op_i == OP_JUMP |=>
    pc_load_o && pc_o == {$past(pclatch_i[6:3]), $past(jaddr_i)})
    else $error("jump target wrong");
  jump_two_a: assert property (tk && op_i == OP_JUMP |=>
    squash_o && !done_o ##1 done_o) else $error("jump not two cycles");
  skip_zero_a: assert property (tk && op_i == OP_INCSZ &&
    fdata_i == 8'hFF |=> squash_o && busy_o ##1 done_o)
    else $error("skip missing");
  no_skip_a: assert property (tk && op_i == OP_INCSZ &&
    fdata_i != 8'hFF |=> !squash_o && done_o) else $error("bad skip");
  skip_flags_a: assert property (tk && op_i == OP_INCSZ |=>
    $stable(zero_o) && $stable(carry_o)) else $error("flags moved");
  or_lit_a: assert property (tk && op_i == OP_ORLIT |=>
    acc_o == ($past(acc_o) | $past(lit_i)) && zero_o == (acc_o == 8'h00))
    else $error("or literal wrong");
  shift_a: assert property (tk && op_i == OP_SHL |=>
    carry_o == $past(fdata_i[7]) && zero_o == ($past(fdata_i[6:0]) == 0))
    else $error("shift flags wrong");
  dest_wr_a: assert property (tk && op_i == OP_INC && dest_i |=>
    fwe_o && fwaddr_o == $past(faddr_i) && fwdata_o == $past(fdata_i) + 8'h01)
    else $error("file write wrong");
  cover property (tk && op_i == OP_JUMP);
  cover property (tk && op_i == OP_INCSZ && fdata_i == 8'hFF);
  cover property (tk && op_i == OP_ORREG && dest_i);
endmodule : iosb_chk
bind iosb_exec iosb_chk iosb_chk_inst (.*);

// ==== tb/iosb_freg.sv ====
// file-register memory on the far side of the execute block
// assumes read data follows the address in the same cycle
`timescale 1ns/10ps
module iosb_freg
  import iosb_pkg::*;
(
  input  wire logic              mclk_i, we_i,
  input  wire logic [ADDR_W-1:0] raddr_i, waddr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem [128];
  assign rdata_o = mem[raddr_i];
  always @(posedge mclk_i) if (we_i) mem[waddr_i] <= wdata_i;
  task poke(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    mem[a] = d;
  endtask : poke
endmodule : iosb_freg

// ==== tb/iosb_tb.sv ====
// self-checking bench for the execute block
// assumes the file-register model answers reads combinationally
`timescale 1ns/10ps
module incr_or_shift_branch_exec_tb_top;
  import iosb_pkg::*;
  logic mclk_i = 0, rst_b_i = 0, valid_i = 0, dest_i = 0;
  logic fwe_o, zero_o, carry_o, pc_load_o, squash_o, busy_o, done_o;
  iosb_op_t          op_i = OP_NONE;
  logic [ADDR_W-1:0] faddr_i = 7'h00, fwaddr_o;
  logic [DATA_W-1:0] lit_i = 8'h00, fdata_i, fwdata_o, acc_o;
  logic [JMP_W-1:0]  jaddr_i = 11'h7FF;
  logic [6:0]        pclatch_i = 7'h58;
  logic [PC_W-1:0]   pc_o;
  int err_total = 0, tests_run = 0, cyc = 0;
  iosb_exec iosb_exec_inst (.*);
  iosb_freg iosb_freg_inst (.mclk_i, .we_i(fwe_o), .raddr_i(faddr_i),
    .waddr_i(fwaddr_o), .wdata_i(fwdata_o), .rdata_o(fdata_i));
  always #50 mclk_i = ~mclk_i;
  task chk(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task go(input iosb_op_t o, input logic [6:0] a, input logic d, l7);
    @(posedge mclk_i);
    valid_i <= 1'b1;
    op_i <= o;
    faddr_i <= a;
    dest_i <= d;
    lit_i <= {l7, 7'h00};
    @(posedge mclk_i);
    valid_i <= 1'b0;
    #1;
  endtask : go
  task t_inc;
    iosb_freg_inst.poke(7'h05, 8'hFF);
    go(OP_INC, 7'h05, 1'b1, 1'b0);
    chk("fwdata", 8'h00, fwdata_o);
    chk("fwe", 1'b1, fwe_o);
    chk("fwaddr", 7'h05, fwaddr_o);
    chk("zero", 1'b1, zero_o);
    go(OP_INC, 7'h05, 1'b0, 1'b0);
    chk("acc", 8'h01, acc_o);
  endtask : t_inc
  task t_skip;
    iosb_freg_inst.poke(7'h09, 8'hFF);
    go(OP_INCSZ, 7'h09, 1'b1, 1'b0);
    chk("squash", 1'b1, squash_o);
    chk("zero", 1'b0, zero_o);
    @(posedge mclk_i);
    #1 chk("done", 1'b1, done_o);
    @(posedge mclk_i);
    go(OP_INCSZ, 7'h09, 1'b0, 1'b0);
    chk("squash", 1'b0, squash_o);
  endtask : t_skip
  task t_or;
    go(OP_ORLIT, 7'h00, 1'b0, 1'b1);
    chk("acc", 8'h81, acc_o);
    go(OP_ORREG, 7'h09, 1'b1, 1'b0);
    chk("fwdata", 8'h81, fwdata_o);
    chk("zero", 1'b0, zero_o);
  endtask : t_or
  task t_shl;
    iosb_freg_inst.poke(7'h03, 8'h80);
    go(OP_SHL, 7'h03, 1'b0, 1'b0);
    chk("acc", 8'h00, acc_o);
    chk("carry", 1'b1, carry_o);
  endtask : t_shl
  task t_jump;
    go(OP_JUMP, 7'h00, 1'b0, 1'b0);
    chk("pc", 15'h5FFF, pc_o);
    chk("zero", 1'b1, zero_o);
    @(posedge mclk_i);
    #1 chk("done", 1'b1, done_o);
  endtask : t_jump
  task wrap_up;
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 500)
    begin
      err_total++;
      wrap_up;
    end
  end
  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_inc;
    t_skip;
    t_or;
    t_shl;
    t_jump;
    wrap_up;
  end
endmodule : incr_or_shift_branch_exec_tb_top
